// ### rstlv_regs.svh
// Register offsets, field positions, reset values, code limits and event indices.
`ifndef RSTLV_REGS_SVH
`define RSTLV_REGS_SVH
// Register indices; each register is one word, so its byte address is four
// times its index.
`define RSTLV_FLAGS_IDX 12'h0E8
`define RSTLV_LVRC_IDX 12'h0D8
`define RSTLV_LVIC_IDX 12'h086
`define RSTLV_FLAGS_OFF (`RSTLV_FLAGS_IDX * 12'h004)
`define RSTLV_LVRC_OFF (`RSTLV_LVRC_IDX * 12'h004)
`define RSTLV_LVIC_OFF (`RSTLV_LVIC_IDX * 12'h004)
`define RSTLV_STATUS_OFF 12'h400
`define RSTLV_MASK_OFF 12'h404
`define RSTLV_FLAGS_RESET 8'h80
`define RSTLV_LVRC_RESET 8'h00
`define RSTLV_LVIC_RESET 8'h00
`define RSTLV_BIT_POR 7
`define RSTLV_BIT_EXT 6
`define RSTLV_BIT_WDT 5
`define RSTLV_BIT_DBG 4
`define RSTLV_BIT_LVR 3
`define RSTLV_BIT_REARM 7
`define RSTLV_BIT_THR_HI 4
`define RSTLV_BIT_THR_LO 1
`define RSTLV_BIT_DIS 0
`define RSTLV_BIT_DET 5
`define RSTLV_BIT_IEN 4
`define RSTLV_BIT_LVL_HI 3
`define RSTLV_BIT_LVL_LO 0
`define RSTLV_LVL_MAX 4'hC
`define RSTLV_THR_MAX 4'hD
`define RSTLV_EV_ST 0
`define RSTLV_EV_DET 1
`define RSTLV_EV_N 2
`endif

// ### rstlv_pkg.sv
// Types shared by the reset flag and low-voltage control block.
package rstlv_pkg;
	// One warm reset cause, sampled at the moment the warm reset ends.
	typedef struct packed {
		logic ext;
		logic wdt;
		logic dbg;
		logic undervoltage_reset;
	} reset_cause_s;
	// One decoded APB access.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} reg_access_s;
endpackage : rstlv_pkg

// ### pin_sync.sv
// Three-stage synchroniser; a change counts once stages two and three agree.
module pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output logic level
);
	logic [2:0] stage;

	// Shift the pin through three flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= 3'h0;
		end else begin
			stage <= {stage[1:0], pin};
		end
	end

	// Hold the level until the two later stages agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 1'b0;
		end else if (stage[2] == stage[1]) begin
			level <= stage[2];
		end
	end
endmodule : pin_sync

// ### apb_byte_slave.sv
// APB slave front end that turns bus transfers into byte register strobes.
module apb_byte_slave
	import rstlv_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output rstlv_pkg::reg_access_s acc,
	output logic [11:0] rd_addr
);
	// Writes take effect in the access phase; zero wait states.
	always_comb begin
		acc.wr = psel && penable && pwrite && pstrb[0];
		acc.rd = psel && penable && !pwrite;
		acc.addr = paddr;
		acc.wdata = pwdata[7:0];
		rd_addr = paddr;
	end
endmodule : apb_byte_slave

// ### reset_flag_and_low_voltage_ctrl.sv
// Reset source flags, low-voltage reset and indicator control over APB.
//
// Contract
// RL1: Zero write or power-on clears low-voltage flag.
// RL2: Power-on sets power flag, clears watchdog, debug.
// RL3: External flag undefined after power-on, set later.
// RL4: Low-voltage flag undefined after power-on, set later.
// RL5: Warm reset sets only its flag.
// RL6: Re-arm set: stop release clears disable bit.
// RL7: Re-arm clear: stop release leaves disable bit.
// RL8: Threshold kept except on power-on reset.
// RL9: Software keeps threshold zero while disabled.
// RL10: Reset control layout: rearm 7, threshold 4:1, disable 0.
// RL11: Indicator layout: flag 5, enable 4, level 3:0.
// RL12: Low-voltage reset active only while disable bit zero.
// RL13: Flag register at E8, reset 80, bits 7..3.
// RL14: Power flag cleared only by zero write.
// RL15: Indicator flags below level; codes above C invalid.
// RL16: Software avoids threshold codes E and F.
`include "rstlv_regs.svh"
module reset_flag_and_low_voltage_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic warm_reset_n,
	input wire rstlv_pkg::reset_cause_s cause,
	input wire logic stop_release,
	input wire logic supply_below_level,
	input wire logic supply_below_threshold,
	output logic undervoltage_reset_req,
	output logic [3:0] reset_threshold_select,
	output logic [3:0] indicator_level_select,
	output logic irq
);
	import rstlv_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	reg_access_s acc;
	logic [11:0] rd_addr;
	logic warm_sync;
	logic warm_prev;
	logic below_sync;
	logic [7:0] flags;
	logic stop_release_rearm;
	logic low_voltage_reset_disable;
	logic indicator_detect_flag;
	logic indicator_enable;
	logic [`RSTLV_EV_N-1:0] status;
	logic [`RSTLV_EV_N-1:0] mask;
	logic [`RSTLV_EV_N-1:0] events;
	logic warm_end;
	logic wr_flags;
	logic wr_lvrc;
	logic wr_lvic;
	logic rd_status;
	logic mapped;
	logic [7:0] next_rdata;
	logic detect_set;

	// ------------------------------------------------------------
	// Bus front end and input synchronisers
	// ------------------------------------------------------------
	apb_byte_slave bus (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.acc(acc),
		.rd_addr(rd_addr)
	);

	pin_sync warm_sync_i (
		.pclk(pclk),
		.presetn(presetn),
		.pin(warm_reset_n),
		.level(warm_sync)
	);

	pin_sync below_sync_i (
		.pclk(pclk),
		.presetn(presetn),
		.pin(supply_below_level),
		.level(below_sync)
	);

	// Decode strobes for each register except the mask, which decodes its own write.
	assign wr_flags = acc.wr && (acc.addr == `RSTLV_FLAGS_OFF);
	assign wr_lvrc = acc.wr && (acc.addr == `RSTLV_LVRC_OFF);
	assign wr_lvic = acc.wr && (acc.addr == `RSTLV_LVIC_OFF);
	assign rd_status = acc.rd && (acc.addr == `RSTLV_STATUS_OFF);
	assign mapped = (acc.addr == `RSTLV_FLAGS_OFF)
		|| (acc.addr == `RSTLV_LVRC_OFF)
		|| (acc.addr == `RSTLV_LVIC_OFF)
		|| (acc.addr == `RSTLV_STATUS_OFF)
		|| (acc.addr == `RSTLV_MASK_OFF);

	// ------------------------------------------------------------
	// Warm reset tracking
	// ------------------------------------------------------------
	// Remember the previous warm reset level to find its release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_prev <= 1'b1;
		end else begin
			warm_prev <= warm_sync;
		end
	end

	// Synchroniser output starts low, so hold the first release back.
	logic warm_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_seen <= 1'b0;
		end else if (warm_sync) begin
			warm_seen <= 1'b1;
		end
	end

	assign warm_end = warm_sync && !warm_prev && warm_seen;

	// ------------------------------------------------------------
	// Reset source flags
	// ------------------------------------------------------------
	// presetn is the power-on reset; warm causes set only their own bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= `RSTLV_FLAGS_RESET; // RL2 RL13
		end else begin
			if (wr_flags) begin
				flags[`RSTLV_BIT_POR] <= flags[`RSTLV_BIT_POR]
					& acc.wdata[`RSTLV_BIT_POR]; // RL14
				flags[`RSTLV_BIT_EXT] <= flags[`RSTLV_BIT_EXT]
					& acc.wdata[`RSTLV_BIT_EXT];
				flags[`RSTLV_BIT_WDT] <= flags[`RSTLV_BIT_WDT]
					& acc.wdata[`RSTLV_BIT_WDT];
				flags[`RSTLV_BIT_DBG] <= flags[`RSTLV_BIT_DBG]
					& acc.wdata[`RSTLV_BIT_DBG];
				flags[`RSTLV_BIT_LVR] <= flags[`RSTLV_BIT_LVR]
					& acc.wdata[`RSTLV_BIT_LVR]; // RL1
			end
			// A cause arriving with a clearing write wins over it.
			if (warm_end) begin
				if (cause.ext) begin
					flags[`RSTLV_BIT_EXT] <= 1'b1; // RL3 RL5
				end
				if (cause.wdt) begin
					flags[`RSTLV_BIT_WDT] <= 1'b1; // RL5
				end
				if (cause.dbg) begin
					flags[`RSTLV_BIT_DBG] <= 1'b1; // RL5
				end
				if (cause.undervoltage_reset) begin
					flags[`RSTLV_BIT_LVR] <= 1'b1; // RL4 RL5
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Low-voltage reset control
	// ------------------------------------------------------------
	// Threshold survives warm resets because only presetn and register writes change it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_threshold_select <= 4'h0; // RL8
		end else if (wr_lvrc) begin
			reset_threshold_select <= acc.wdata[`RSTLV_BIT_THR_HI:
				`RSTLV_BIT_THR_LO]; // RL10
		end
	end

	// Re-arm bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_release_rearm <= 1'b0;
		end else if (wr_lvrc) begin
			stop_release_rearm <= acc.wdata[`RSTLV_BIT_REARM]; // RL10
		end
	end

	// Disable bit; stop release with re-arm set clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_voltage_reset_disable <= 1'b0;
		end else if (stop_release && stop_release_rearm) begin
			low_voltage_reset_disable <= 1'b0; // RL6
		end else if (wr_lvrc) begin
			low_voltage_reset_disable <= acc.wdata[`RSTLV_BIT_DIS]; // RL7
		end
	end

	// Reset request only while enabled; software keeps code below E.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			undervoltage_reset_req <= 1'b0;
		end else begin
			undervoltage_reset_req <= !low_voltage_reset_disable
				&& supply_below_threshold
				&& (reset_threshold_select <= `RSTLV_THR_MAX); // RL12 RL16
		end
	end

	// ------------------------------------------------------------
	// Low-voltage indicator
	// ------------------------------------------------------------
	assign detect_set = indicator_enable && below_sync
		&& (indicator_level_select <= `RSTLV_LVL_MAX);

	// Enable and level select.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_enable <= 1'b0;
			indicator_level_select <= 4'h0;
		end else if (wr_lvic) begin
			indicator_enable <= acc.wdata[`RSTLV_BIT_IEN]; // RL11
			indicator_level_select <= acc.wdata[`RSTLV_BIT_LVL_HI:
				`RSTLV_BIT_LVL_LO]; // RL11
		end
	end

	// Detect flag is sticky; a set in the clearing cycle wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_detect_flag <= 1'b0;
		end else if (detect_set) begin
			indicator_detect_flag <= 1'b1; // RL15
		end else if (wr_lvic) begin
			indicator_detect_flag <= indicator_detect_flag
				& acc.wdata[`RSTLV_BIT_DET];
		end
	end

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	assign events[`RSTLV_EV_ST] = stop_release;
	assign events[`RSTLV_EV_DET] = detect_set && !indicator_detect_flag;

	// Status bits are cleared by reading; new events win.
	genvar gi;
	generate
		for (gi = 0; gi < `RSTLV_EV_N; gi++) begin : ev
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status[gi] <= 1'b0;
				end else if (events[gi]) begin
					status[gi] <= 1'b1;
				end else if (rd_status) begin
					status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
		end else if (acc.wr && (acc.addr == `RSTLV_MASK_OFF)) begin
			mask <= acc.wdata[`RSTLV_EV_N-1:0];
		end
	end

	// Interrupt level output.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		case (rd_addr)
			`RSTLV_FLAGS_OFF: next_rdata = flags & 8'hF8;
			`RSTLV_LVRC_OFF: next_rdata = {stop_release_rearm, 2'b00,
				reset_threshold_select, low_voltage_reset_disable};
			`RSTLV_LVIC_OFF: next_rdata = {2'b00, indicator_detect_flag,
				indicator_enable, indicator_level_select};
			`RSTLV_STATUS_OFF: next_rdata = {6'h00, status};
			`RSTLV_MASK_OFF: next_rdata = {6'h00, mask};
			default: next_rdata = 8'h00;
		endcase
	end

	// Answer in the cycle after setup; pready is high only then.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= {24'h0, next_rdata};
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	por_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_flags && !acc.wdata[`RSTLV_BIT_POR]
		|=> !flags[`RSTLV_BIT_POR]) // RL14
		else $error("power flag not cleared by zero write");
	lvr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_flags && !acc.wdata[`RSTLV_BIT_LVR] && !warm_end
		|=> !flags[`RSTLV_BIT_LVR]) // RL1
		else $error("low-voltage flag not cleared");
	ext_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		warm_end && cause.ext |=> flags[`RSTLV_BIT_EXT]) // RL3
		else $error("external flag not set");
	lvr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		warm_end && cause.undervoltage_reset |=> flags[`RSTLV_BIT_LVR]) // RL4
		else $error("low-voltage flag not set");
	flags_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!warm_end && !wr_flags |=> $stable(flags)) // RL5
		else $error("flags changed with no cause");
	rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_release && stop_release_rearm
		|=> !low_voltage_reset_disable) // RL6
		else $error("disable bit not cleared at stop release");
	no_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_release && !stop_release_rearm && !wr_lvrc
		|=> $stable(low_voltage_reset_disable)) // RL7
		else $error("disable bit changed without re-arm");
	thr_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_lvrc |=> $stable(reset_threshold_select)) // RL8
		else $error("threshold changed without write");
	disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset_disable |=> !undervoltage_reset_req) // RL12
		else $error("reset request while disabled");
	detect_a: assert property (@(posedge pclk) disable iff (!presetn)
		detect_set |=> indicator_detect_flag) // RL15
		else $error("detect flag not set");
	lvic_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_lvic |=> indicator_level_select
		== $past(acc.wdata[`RSTLV_BIT_LVL_HI:`RSTLV_BIT_LVL_LO])) // RL11
		else $error("level select not stored");
	warm_cv: cover property (@(posedge pclk) disable iff (!presetn)
		warm_end && cause.wdt);
	rearm_cv: cover property (@(posedge pclk) disable iff (!presetn)
		stop_release && stop_release_rearm);
	detect_cv: cover property (@(posedge pclk) disable iff (!presetn)
		detect_set ##1 irq);
endmodule : reset_flag_and_low_voltage_ctrl

// ### reset_flag_and_low_voltage_ctrl_test.sv
// Self-checking testbench for the reset flag and low-voltage control block.
`include "rstlv_regs.svh"
module reset_flag_and_low_voltage_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rstlv_pkg::*;
	// ------------------------------------------------------------
	// Signals and expected-result notes
	// ------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic [7:0] d;
		logic err;
	} note_s;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, reset_threshold_select, indicator_level_select;
	logic warm_reset_n, stop_release, supply_below_level;
	logic supply_below_threshold, undervoltage_reset_req, irq;
	reset_cause_s cause;
	note_s notes[$];
	int miscompares = 0;
	int samples_checked = 0;
	logic [3:0] thr, lvl, acc;
	// The clock toggles every half period of 25 ns.
	always #25 pclk = ~pclk;
	reset_flag_and_low_voltage_ctrl reset_flag_and_low_voltage_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.warm_reset_n(warm_reset_n), .cause(cause),
		.stop_release(stop_release), .supply_below_level(supply_below_level),
		.supply_below_threshold(supply_below_threshold),
		.undervoltage_reset_req(undervoltage_reset_req),
		.reset_threshold_select(reset_threshold_select),
		.indicator_level_select(indicator_level_select), .irq(irq)
	);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Compares one value, counting the comparison and any mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	// One APB transfer; the expected answer is noted before it starts.
	task automatic xfer(input logic wr, input logic [11:0] a,
			input logic [7:0] d, input logic [7:0] exp, input logic err);
		int n;
		n = 0;
		notes.push_back('{~wr, exp, err});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: no bus answer", $time);
			give_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	// Holds a warm reset with one cause and waits until it is recorded.
	task automatic warm(input reset_cause_s c);
		cause <= c;
		warm_reset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		warm_reset_n <= 1'b1;
		repeat (10) @(posedge pclk);
		cause <= 4'h0;
	endtask : warm
	// Gives one single-cycle stop release pulse.
	task automatic stop_pulse;
		stop_release <= 1'b1;
		@(posedge pclk);
		stop_release <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : stop_pulse
	// ------------------------------------------------------------
	// Watcher: takes the oldest note whenever an answer appears
	// ------------------------------------------------------------
	always @(posedge pclk) begin
		note_s nt;
		if (presetn === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) begin
				miscompares++;
				$display("mismatch at %0t: answer with no request", $time);
			end else begin
				nt = notes.pop_front();
				chk({31'h0, pslverr}, {31'h0, nt.err});
				if (nt.rd) begin
					chk(prdata, {24'h000000, nt.d});
				end
			end
		end
	end
	// A hung run is cut short and judged as failed.
	initial begin
		#3000000;
		miscompares++;
		$display("mismatch at %0t: run limit reached", $time);
		give_verdict();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, stop_release} = 5'h00;
		{supply_below_level, supply_below_threshold} = 2'b00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		warm_reset_n = 1'b1;
		cause = 4'h0;
		void'($urandom(32'h22E59F5A));
		thr = 4'($urandom_range(13, 1));
		lvl = 4'($urandom_range(12, 0));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `RSTLV_FLAGS_OFF, 8'h00, 8'h80, 1'b0);
		xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, 8'h00, 1'b0);
		xfer(1'b0, `RSTLV_LVIC_OFF, 8'h00, 8'h00, 1'b0);
		xfer(1'b1, 12'h7F0, 8'h5A, 8'h00, 1'b1);
		xfer(1'b0, 12'h7F0, 8'h00, 8'h00, 1'b1);
		xfer(1'b1, `RSTLV_LVRC_OFF, {3'b000, thr, 1'b0}, 8'h00, 1'b0);
		xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, {3'b000, thr, 1'b0}, 1'b0);
		chk({28'h0, reset_threshold_select}, {28'h0, thr});
		// Each warm cause sets its own flag and keeps the others.
		acc = 4'h0;
		for (int i = 0; i < 4; i++) begin
			warm(4'h8 >> i);
			acc = acc | (4'h8 >> i);
			xfer(1'b0, `RSTLV_FLAGS_OFF, 8'h00, {1'b1, acc, 3'b000}, 1'b0);
			xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, {3'b000, thr, 1'b0}, 1'b0);
		end
		xfer(1'b1, `RSTLV_FLAGS_OFF, 8'hF8, 8'h00, 1'b0);
		xfer(1'b0, `RSTLV_FLAGS_OFF, 8'h00, 8'hF8, 1'b0);
		xfer(1'b1, `RSTLV_FLAGS_OFF, 8'h00, 8'h00, 1'b0);
		xfer(1'b0, `RSTLV_FLAGS_OFF, 8'h00, 8'h00, 1'b0);
		// The reset request follows the comparator only while enabled.
		supply_below_threshold <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, undervoltage_reset_req}, 32'h1);
		xfer(1'b1, `RSTLV_LVRC_OFF, 8'h01, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		chk({31'h0, undervoltage_reset_req}, 32'h0);
		supply_below_threshold <= 1'b0;
		// Stop release re-arms only when asked to.
		xfer(1'b1, `RSTLV_LVRC_OFF, 8'h81, 8'h00, 1'b0);
		stop_pulse();
		xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, 8'h80, 1'b0);
		xfer(1'b1, `RSTLV_LVRC_OFF, 8'h01, 8'h00, 1'b0);
		stop_pulse();
		xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, 8'h01, 1'b0);
		// Indicator detection raises an unmasked interrupt.
		xfer(1'b0, `RSTLV_STATUS_OFF, 8'h00, 8'h01, 1'b0);
		xfer(1'b1, `RSTLV_MASK_OFF, 8'h03, 8'h00, 1'b0);
		xfer(1'b1, `RSTLV_LVIC_OFF, {4'h1, lvl}, 8'h00, 1'b0);
		chk({28'h0, indicator_level_select}, {28'h0, lvl});
		supply_below_level <= 1'b1;
		repeat (8) @(posedge pclk);
		supply_below_level <= 1'b0;
		xfer(1'b0, `RSTLV_LVIC_OFF, 8'h00, {4'h3, lvl}, 1'b0);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b0, `RSTLV_STATUS_OFF, 8'h00, 8'h02, 1'b0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		// A masked event stays out of the interrupt but is recorded.
		xfer(1'b1, `RSTLV_MASK_OFF, 8'h00, 8'h00, 1'b0);
		stop_pulse();
		chk({31'h0, irq}, 32'h0);
		xfer(1'b0, `RSTLV_STATUS_OFF, 8'h00, 8'h01, 1'b0);
		// An invalid level code never detects.
		xfer(1'b1, `RSTLV_LVIC_OFF, 8'h1D, 8'h00, 1'b0);
		supply_below_level <= 1'b1;
		repeat (8) @(posedge pclk);
		supply_below_level <= 1'b0;
		xfer(1'b0, `RSTLV_LVIC_OFF, 8'h00, 8'h1D, 1'b0);
		// A power-on reset in mid-run restores the power-on state.
		xfer(1'b1, `RSTLV_LVRC_OFF, {3'b000, thr, 1'b0}, 8'h00, 1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `RSTLV_FLAGS_OFF, 8'h00, 8'h80, 1'b0);
		xfer(1'b0, `RSTLV_LVRC_OFF, 8'h00, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		give_verdict();
	end
endmodule : reset_flag_and_low_voltage_ctrl_test
